/* File: rtl/fms_status.sv */
// FIFO masked status register (bits 1..4) with mask, threshold and clear.
// Assumes FIFO level counts and overrun pulse come from same-clock logic.
// Assumes tx_overrun_pulse is one clock wide for each lost write.
// Limitation: the threshold is 8 bits, so deep FIFOs compare against 255 at most.
// Reads cost one clock; the port never inserts wait states.
//
// Contract
// - Bit 1 set when tx level <= threshold.
// - Bit 2 set while tx FIFO full.
// - Bit 3 set once tx overrun occurred.
// - Bit 4 set while rx FIFO empty.
// - Status bits read-only, reset zero.
`timescale 1ns/1ps
`default_nettype none
module fms_status #(
  parameter int DEPTH = fms_pkg::FMS_FIFO_DEPTH,
  parameter int LW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire fms_pkg::fms_req_t req,
  output logic [31:0] rdata,
  // FIFO side
  input wire logic [LW-1:0] tx_level,
  input wire logic [LW-1:0] rx_level,
  input wire logic tx_overrun_pulse,
  // Interrupt request
  output logic irq
);
  import fms_pkg::*;

  logic [3:0] mask_r;
  logic [7:0] thr_r;
  logic ovr_r;
  logic [3:0] mstat_r;
  logic [31:0] rdata_r;
  logic irq_r;

  // Address decode
  wire wr_mask = req.wr && (req.addr == FMS_OFS_MASK);
  wire wr_thr = req.wr && (req.addr == FMS_OFS_THR);
  wire wr_clr = req.wr && (req.addr == FMS_OFS_CLR);
  wire clr_ovr = wr_clr && req.wdata[FMS_BIT_TXOVR];

  // Raw conditions; widened to 32 bits so any level width compares cleanly
  fms_cond_t raw;
  logic [3:0] raw_vec;
  logic [3:0] mstat_nxt;
  assign raw = '{
    rx_empty: (rx_level == '0),
    tx_overrun: ovr_r,
    tx_full: (32'(tx_level) == 32'(DEPTH)),
    tx_nearly_empty: (32'(tx_level) <= 32'(thr_r))
  };
  assign raw_vec = raw;

  // Per-source enable; one bit per condition, so one loop
  for (genvar g = 0; g < 4; g++) begin : g_mask
    assign mstat_nxt[g] = raw_vec[g] & mask_r[g];
  end

  // Control registers, writable by software
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mask_r <= FMS_RST_MASK;
      thr_r <= FMS_RST_THR;
    end else begin
      if (wr_mask) mask_r <= req.wdata[FMS_BIT_RXEMPTY:FMS_BIT_TXNE];
      if (wr_thr) thr_r <= req.wdata[7:0];
    end
  end

  // Sticky overrun; a new event wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) ovr_r <= 1'b0;
    else ovr_r <= tx_overrun_pulse | (ovr_r & ~clr_ovr);
  end

  // Masked status held in flops; no write path reaches it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mstat_r <= FMS_RST_MSTAT[FMS_BIT_RXEMPTY:FMS_BIT_TXNE];
      irq_r <= 1'b0;
    end else begin
      mstat_r <= mstat_nxt;
      irq_r <= |mstat_nxt;
    end
  end

  // Read mux; unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (req.addr)
      FMS_OFS_MSTAT: rd_mux = {27'h0, mstat_r, 1'b0};
      FMS_OFS_MASK: rd_mux = {27'h0, mask_r, 1'b0};
      FMS_OFS_THR: rd_mux = {24'h0, thr_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Registered read data; zero between reads so stale words never linger
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) rdata_r <= 32'h0000_0000;
    else if (req.rd) rdata_r <= rd_mux;
    else rdata_r <= 32'h0000_0000;
  end

  // Outputs straight from flops
  assign rdata = rdata_r;
  assign irq = irq_r;

  // Assertions; reference values are rebuilt from the ports and registers, not from raw, except mstat_nxt in the read-only and irq checks
  wire chk_txne = (32'(tx_level) <= 32'(thr_r)) && mask_r[0];
  wire [3:0] wr_mask_val = req.wdata[FMS_BIT_RXEMPTY:FMS_BIT_TXNE];
  wire [7:0] wr_thr_val = req.wdata[7:0];
  wire rd_unmapped = (req.addr != FMS_OFS_MSTAT) && (req.addr != FMS_OFS_MASK)
    && (req.addr != FMS_OFS_THR);
  AST_TXNE: assert property (@(posedge mclk) disable iff (!rst_b)
    mstat_r[0] == $past(chk_txne))
    else $error("nearly empty bit wrong");
  AST_TXNE_THR: assert property (@(posedge mclk) disable iff (!rst_b)
    (mask_r[0] && tx_level <= thr_r && $stable(mask_r) && $stable(thr_r) && $stable(tx_level))
    |=> mstat_r[0]) else $error("nearly empty not reported");
  AST_TXFULL: assert property (@(posedge mclk) disable iff (!rst_b)
    (mask_r[1] && 32'(tx_level) == DEPTH) ##1 $stable(mask_r) |-> mstat_r[1])
    else $error("full not reported");
  AST_TXFULL_N: assert property (@(posedge mclk) disable iff (!rst_b)
    (32'(tx_level) != DEPTH) |=> !mstat_r[1]) else $error("full reported falsely");
  AST_OVR: assert property (@(posedge mclk) disable iff (!rst_b)
    tx_overrun_pulse |=> ovr_r) else $error("overrun lost");
  AST_OVR_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
    (ovr_r && !clr_ovr) |=> ovr_r) else $error("overrun dropped");
  AST_RXE: assert property (@(posedge mclk) disable iff (!rst_b)
    (rx_level != '0) |=> !mstat_r[3]) else $error("rx empty reported falsely");
  AST_RO: assert property (@(posedge mclk) disable iff (!rst_b)
    (req.wr && req.addr == FMS_OFS_MSTAT) |=> mstat_r == $past(mstat_nxt))
    else $error("status changed by write");
  AST_IRQ: assert property (@(posedge mclk) disable iff (!rst_b)
    irq == |mstat_r) else $error("irq not OR of bits");
  COV_OVR: cover property (@(posedge mclk) tx_overrun_pulse ##1 clr_ovr);
  COV_FULL: cover property (@(posedge mclk) mstat_r[1]);
  COV_IRQ: cover property (@(posedge mclk) $rose(irq));
  COV_SETCLR: cover property (@(posedge mclk) tx_overrun_pulse && clr_ovr);
  COV_RXE: cover property (@(posedge mclk) mstat_r[3]);

  // Nearly empty must drop when masked off or above the threshold
  AST_TXNE_N: assert property (@(posedge mclk) disable iff (!rst_b)
    (!mask_r[0] || 32'(tx_level) > 32'(thr_r)) |=> !mstat_r[0])
    else $error("nearly empty reported falsely");

  // Full and receive empty reported while enabled
  AST_TXFULL_ON: assert property (@(posedge mclk) disable iff (!rst_b)
    (mask_r[1] && 32'(tx_level) == 32'(DEPTH)) |=> mstat_r[1])
    else $error("full not reported at once");
  AST_RXE_SET: assert property (@(posedge mclk) disable iff (!rst_b)
    (mask_r[3] && rx_level == '0) |=> mstat_r[3])
    else $error("rx empty not reported");

  // Overrun: visible when enabled, cleared only by the clear word
  AST_OVR_VIS: assert property (@(posedge mclk) disable iff (!rst_b)
    (mask_r[2] && ovr_r) |=> mstat_r[2])
    else $error("overrun not reported");
  AST_OVR_CLR: assert property (@(posedge mclk) disable iff (!rst_b)
    (clr_ovr && !tx_overrun_pulse) |=> !ovr_r)
    else $error("overrun not cleared");
  AST_OVR_WINS: assert property (@(posedge mclk) disable iff (!rst_b)
    (clr_ovr && tx_overrun_pulse) |=> ovr_r)
    else $error("overrun lost to clear");
  AST_OVR_QUIET: assert property (@(posedge mclk) disable iff (!rst_b)
    (!ovr_r && !tx_overrun_pulse) |=> !ovr_r)
    else $error("overrun set without event");

  // A closed mask hides every source and the request
  AST_MASK_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
    (mask_r == 4'h0) |=> (mstat_r == 4'h0 && !irq))
    else $error("masked source leaked");
  AST_IRQ_ON: assert property (@(posedge mclk) disable iff (!rst_b)
    (|mstat_nxt) |=> irq)
    else $error("irq not raised");
  AST_IRQ_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
    (mstat_nxt == 4'h0) |=> !irq)
    else $error("irq raised without source");

  // Control words take the written value and otherwise hold
  AST_MASK_WR: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_mask |=> mask_r == $past(wr_mask_val))
    else $error("mask write lost");
  AST_MASK_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
    !wr_mask |=> $stable(mask_r))
    else $error("mask changed without write");
  AST_THR_WR: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_thr |=> thr_r == $past(wr_thr_val))
    else $error("threshold write lost");
  AST_THR_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
    !wr_thr |=> $stable(thr_r))
    else $error("threshold changed without write");

  // Read port: data only in the cycle after the strobe
  AST_RD_IDLE: assert property (@(posedge mclk) disable iff (!rst_b)
    !req.rd |=> rdata == 32'h0000_0000)
    else $error("read data outside read");
  AST_RD_STAT: assert property (@(posedge mclk) disable iff (!rst_b)
    (req.rd && req.addr == FMS_OFS_MSTAT) |=> rdata == {27'h0, $past(mstat_r), 1'b0})
    else $error("status read wrong");
  AST_RD_MASK: assert property (@(posedge mclk) disable iff (!rst_b)
    (req.rd && req.addr == FMS_OFS_MASK) |=> rdata == {27'h0, $past(mask_r), 1'b0})
    else $error("mask read wrong");
  AST_RD_THR: assert property (@(posedge mclk) disable iff (!rst_b)
    (req.rd && req.addr == FMS_OFS_THR) |=> rdata == {24'h0, $past(thr_r)})
    else $error("threshold read wrong");
  AST_RD_UNMAP: assert property (@(posedge mclk) disable iff (!rst_b)
    (req.rd && rd_unmapped) |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Reset drives every output and status flop to zero; second low edge skips start-up
  AST_RST: assert property (@(posedge mclk)
    (!rst_b && !$past(rst_b)) |->
    (mstat_r == 4'h0 && ovr_r == 1'b0 && irq == 1'b0 && rdata == 32'h0000_0000))
    else $error("reset value wrong");
endmodule // fms_status
`default_nettype wire

/* File: rtl/fms_pkg.sv */
// Package for the FIFO masked status fragment of the two-wire controller.
// Assumes a single 50 MHz clock domain and a plain register port.
package fms_pkg;
  // Register map, word offsets as byte addresses
  localparam logic [7:0] FMS_OFS_MSTAT = 8'h00;
  localparam logic [7:0] FMS_OFS_MASK = 8'h04;
  localparam logic [7:0] FMS_OFS_THR = 8'h08;
  localparam logic [7:0] FMS_OFS_CLR = 8'h0c;
  // Field positions inside the status and mask words
  localparam int FMS_BIT_TXNE = 1;
  localparam int FMS_BIT_TXFULL = 2;
  localparam int FMS_BIT_TXOVR = 3;
  localparam int FMS_BIT_RXEMPTY = 4;
  // Reset values
  localparam logic [31:0] FMS_RST_MSTAT = 32'h0000_0000;
  localparam logic [3:0] FMS_RST_MASK = 4'h0;
  localparam logic [7:0] FMS_RST_THR = 8'h00;
  // Default FIFO depth
  localparam int FMS_FIFO_DEPTH = 16;

  // Raw FIFO conditions travelling together
  typedef struct packed {
    logic rx_empty;
    logic tx_overrun;
    logic tx_full;
    logic tx_nearly_empty;
  } fms_cond_t;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } fms_req_t;
endpackage : fms_pkg

/* File: testbench/test_fms.sv */
// Bench: random levels, mask and threshold against an integer model.
// Assumes reads answer one cycle after the strobe, status lags one clock.
`timescale 1ns/1ps
`default_nettype none
module test_i2c_fifo_masked_irq_status;
  import fms_pkg::*;
  logic mclk, rst_b, ovp, irq, sticky;
  fms_req_t req;
  logic [31:0] rdata;
  logic [4:0] tx_level, rx_level;
  logic [3:0] mask;
  logic [7:0] thr;
  int fail_count, checks, seed, cyc, i;
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
  fms_status dut_u (.mclk(mclk), .rst_b(rst_b), .req(req), .rdata(rdata),
    .tx_level(tx_level), .rx_level(rx_level), .tx_overrun_pulse(ovp), .irq(irq));
  // Bus cycles; release one edge later so strobes never double up
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{w, !w, a, d};
    @(posedge mclk);
    req <= '0;
    #1;
  endtask
  // Model: raw condition AND mask, placed at bits 4:1
  function automatic logic [31:0] model();
    logic [3:0] raw;
    raw = {rx_level == 0, sticky, int'(tx_level) == FMS_FIFO_DEPTH, {3'h0, tx_level} <= thr};
    return {27'h0, raw & mask, 1'b0};
  endfunction
  // Let two edges pass so registered status settles first
  task automatic check_all();
    repeat (2) @(posedge mclk);
    bus(1'b0, FMS_OFS_MSTAT, 32'h0);
    `CHK("status", model(), rdata)
    `CHK("irq", |model(), irq)
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    {rst_b, ovp, sticky, mask, thr, tx_level, rx_level} = '0;
    req = '0;
    seed = 57950;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    check_all();
    bus(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h0, rdata)
    $display("reset test done");
    for (i = 0; i < 40; i++) begin
      @(posedge mclk);
      tx_level <= 5'($unsigned($random(seed)) % 17);
      rx_level <= 5'($unsigned($random(seed)) % 3);
      mask = 4'($random(seed));
      thr = 8'($unsigned($random(seed)) % 17);
      bus(1'b1, FMS_OFS_MASK, {27'h0, mask, 1'b0});
      bus(1'b1, FMS_OFS_THR, {24'h0, thr});
      bus(1'b0, FMS_OFS_MASK, 32'h0);
      `CHK("mask", {27'h0, mask, 1'b0}, rdata)
      bus(1'b0, FMS_OFS_THR, 32'h0);
      `CHK("thr", {24'h0, thr}, rdata)
      if (i % 9 == 4) bus(1'b1, FMS_OFS_MSTAT, 32'hffff_ffff);
      if (i % 5 == 2) begin
        @(posedge mclk);
        ovp <= 1'b1;
        @(posedge mclk);
        ovp <= 1'b0;
        sticky = 1'b1;
      end
      if (i % 7 == 3) begin
        bus(1'b1, FMS_OFS_CLR, 32'h8);
        sticky = 1'b0;
      end
      check_all();
    end
    $display("random test done");
    // Overrun event and clear in one cycle: the event must win
    mask = 4'hf;
    bus(1'b1, FMS_OFS_MASK, 32'h1e);
    @(posedge mclk);
    req <= '{1'b1, 1'b0, FMS_OFS_CLR, 32'h8};
    ovp <= 1'b1;
    @(posedge mclk);
    req <= '0;
    ovp <= 1'b0;
    sticky = 1'b1;
    check_all();
    $display("set wins test done");
    // Reset again mid-run: everything back to zero
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK("irq_rst", 1'b0, irq)
    rst_b <= 1'b1;
    {mask, thr, sticky} = '0;
    check_all();
    bus(1'b0, FMS_OFS_MASK, 32'h0);
    `CHK("mask_rst", 32'h0, rdata)
    bus(1'b0, FMS_OFS_THR, 32'h0);
    `CHK("thr_rst", 32'h0, rdata)
    $display("second reset test done");
    stop_test();
  end
endmodule // test_i2c_fifo_masked_irq_status
`default_nettype wire
